// >>> include/rss_defines.svh
// register offsets, field positions and reset values of the rate setting selector
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RSS_ADDR_W          4
`define RSS_OFS_BW_A        4'h4
`define RSS_OFS_BW_B        4'h5
`define RSS_OFS_BW_C        4'h6
`define RSS_OFS_BW_D        4'h7
`define RSS_OFS_LVL_A       4'h8
`define RSS_OFS_LVL_B       4'h9
`define RSS_OFS_LVL_C       4'hA
`define RSS_OFS_LVL_D       4'hB
`define RSS_OFS_ACT_BW      4'hE
`define RSS_OFS_ACT_LVL     4'hF

// ----------------------------------------
// field positions
// ----------------------------------------
`define RSS_OVR_BIT         7
`define RSS_BW_MSB          3
`define RSS_LVL_MSB         6
`define RSS_BW_WR_MASK      8'h8F
`define RSS_LVL_WR_MASK     8'hFF

// ----------------------------------------
// reset values
// ----------------------------------------
`define RSS_CFG_RST         8'h00
`define RSS_RD_RST          8'h00

`endif

// >>> include/rss_pkg.sv
// types shared by the rate setting selector
package rss_pkg;

  // ----------------------------------------
  // register access request
  // ----------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rss_req_t;

  // ----------------------------------------
  // pin-selected setting slot
  // ----------------------------------------
  typedef enum logic [1:0] {
    RSS_SLOT_A,
    RSS_SLOT_B,
    RSS_SLOT_C,
    RSS_SLOT_D
  } rss_slot_t;

endpackage

// >>> hw/rss_top.sv
// rate setting selector: bandwidth and signal loss level register bank
`timescale 1ns/100ps
`include "rss_defines.svh"

module rss_top #(
  parameter logic [3:0] BW_DFLT_A  = 4'h0,
  parameter logic [3:0] BW_DFLT_B  = 4'h0,
  parameter logic [3:0] BW_DFLT_C  = 4'h0,
  parameter logic [3:0] BW_DFLT_D  = 4'h0,
  parameter logic [6:0] LVL_DFLT_A = 7'h00,
  parameter logic [6:0] LVL_DFLT_B = 7'h00,
  parameter logic [6:0] LVL_DFLT_C = 7'h00,
  parameter logic [6:0] LVL_DFLT_D = 7'h00
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // register access from the serial interface logic
  input  wire rss_pkg::rss_req_t i_req,
  output logic [7:0]             o_rd_data,
  output logic                   o_rd_valid,
  // speed select pins
  input  wire logic              i_speed_pin_low,
  input  wire logic              i_speed_pin_high,
  // settings in force
  output logic [3:0]             o_active_bw_code,
  output logic [6:0]             o_active_sig_level_code
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // speed pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_meta_reg <= 2'b00;
      pin_sync_reg <= 2'b00;
    end else begin
      pin_meta_reg <= {i_speed_pin_high, i_speed_pin_low};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // {high, low}; a floating pair resolves to 2'b10 through pad pulls
  function automatic rss_pkg::rss_slot_t slot_of(input logic [1:0] pins);
    case (pins)
      2'b00:   slot_of = rss_pkg::RSS_SLOT_A;
      2'b01:   slot_of = rss_pkg::RSS_SLOT_B;
      2'b11:   slot_of = rss_pkg::RSS_SLOT_C;
      default: slot_of = rss_pkg::RSS_SLOT_D;
    endcase
  endfunction

  wire rss_pkg::rss_slot_t slot = slot_of(pin_sync_reg);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  localparam logic [3:0] BW_OFS [4] = '{`RSS_OFS_BW_A, `RSS_OFS_BW_B,
                                        `RSS_OFS_BW_C, `RSS_OFS_BW_D};
  localparam logic [3:0] LV_OFS [4] = '{`RSS_OFS_LVL_A, `RSS_OFS_LVL_B,
                                        `RSS_OFS_LVL_C, `RSS_OFS_LVL_D};
  localparam logic [3:0] BW_DF  [4] = '{BW_DFLT_A, BW_DFLT_B,
                                        BW_DFLT_C, BW_DFLT_D};
  localparam logic [6:0] LV_DF  [4] = '{LVL_DFLT_A, LVL_DFLT_B,
                                        LVL_DFLT_C, LVL_DFLT_D};

  logic [7:0] bw_reg  [4];
  logic [7:0] lvl_reg [4];
  logic [3:0] bw_eff  [4];
  logic [6:0] lvl_eff [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_slot
      wire bw_we  = i_req.wr && (i_req.addr == BW_OFS[g]);
      wire lvl_we = i_req.wr && (i_req.addr == LV_OFS[g]);

      always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          bw_reg[g]  <= `RSS_CFG_RST;
          lvl_reg[g] <= `RSS_CFG_RST;
        end else begin
          if (bw_we) begin
            bw_reg[g] <= i_req.wdata & `RSS_BW_WR_MASK;
          end
          if (lvl_we) begin
            lvl_reg[g] <= i_req.wdata & `RSS_LVL_WR_MASK;
          end
        end
      end

      // override bit picks programmed field, else the fixed default
      assign bw_eff[g] = bw_reg[g][`RSS_OVR_BIT] ?
                         bw_reg[g][`RSS_BW_MSB:0] : BW_DF[g];
      // code passes straight through: zeros minimum, ones maximum
      assign lvl_eff[g] = lvl_reg[g][`RSS_OVR_BIT] ?
                          lvl_reg[g][`RSS_LVL_MSB:0] : LV_DF[g];
    end
  endgenerate

  // ----------------------------------------
  // setting in force
  // ----------------------------------------
  wire [3:0] bw_sel  = bw_eff[slot];
  wire [6:0] lvl_sel = lvl_eff[slot];

  logic [3:0] act_bw_reg;
  logic [6:0] act_lvl_reg;

  // refreshed every cycle so status tracks pins and writes unprompted
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      act_bw_reg  <= 4'h0;
      act_lvl_reg <= 7'h00;
    end else begin
      act_bw_reg  <= bw_sel;
      act_lvl_reg <= lvl_sel;
    end
  end

  assign o_active_bw_code        = act_bw_reg;
  assign o_active_sig_level_code = act_lvl_reg;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rd_mux;

  // status offsets have no write decode, so writes there fall away
  always_comb begin
    rd_mux = 8'h00;
    case (i_req.addr)
      `RSS_OFS_BW_A:    rd_mux = bw_reg[0];
      `RSS_OFS_BW_B:    rd_mux = bw_reg[1];
      `RSS_OFS_BW_C:    rd_mux = bw_reg[2];
      `RSS_OFS_BW_D:    rd_mux = bw_reg[3];
      `RSS_OFS_LVL_A:   rd_mux = lvl_reg[0];
      `RSS_OFS_LVL_B:   rd_mux = lvl_reg[1];
      `RSS_OFS_LVL_C:   rd_mux = lvl_reg[2];
      `RSS_OFS_LVL_D:   rd_mux = lvl_reg[3];
      `RSS_OFS_ACT_BW:  rd_mux = {4'h0, act_bw_reg};
      `RSS_OFS_ACT_LVL: rd_mux = {1'b0, act_lvl_reg};
      default:          rd_mux = 8'h00;
    endcase
  end

  logic [7:0] rd_data_reg;
  logic       rd_valid_reg;

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_data_reg  <= `RSS_RD_RST;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= i_req.rd;
      if (i_req.rd) begin
        rd_data_reg <= rd_mux;
      end
    end
  end

  assign o_rd_data  = rd_data_reg;
  assign o_rd_valid = rd_valid_reg;

endmodule

// >>> sim/rss_asserts.sv
// port checker for the rate setting selector
`timescale 1ns/100ps
module rss_asserts (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire rss_pkg::rss_req_t i_req,
  input wire logic [7:0]        o_rd_data,
  input wire logic              o_rd_valid,
  input wire logic              i_speed_pin_low,
  input wire logic              i_speed_pin_high,
  input wire logic [3:0]        o_active_bw_code,
  input wire logic [6:0]        o_active_sig_level_code
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [1:0] pins_reg;
  wire        quiet = !i_req.wr && ({i_speed_pin_high, i_speed_pin_low} == pins_reg);
  always_ff @(posedge i_clk) pins_reg <= {i_speed_pin_high, i_speed_pin_low};
  property p_rd_valid; i_req.rd |=> o_rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_no_valid; !i_req.rd |=> !o_rd_valid; endproperty
  a_no_valid: assert property (p_no_valid) else $error("stray read valid");
  property p_rd_hold; !i_req.rd |=> $stable(o_rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_bw; i_req.rd && i_req.addr == 4'hE |=> o_rd_data == {4'h0, $past(o_active_bw_code)}; endproperty
  a_rd_bw: assert property (p_rd_bw) else $error("bandwidth status mismatch");
  property p_rd_lvl; i_req.rd && i_req.addr == 4'hF |=> o_rd_data == {1'b0, $past(o_active_sig_level_code)}; endproperty
  a_rd_lvl: assert property (p_rd_lvl) else $error("level status mismatch");
  property p_unmapped; i_req.rd && i_req.addr < 4'h4 |=> o_rd_data == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_bw_pad; i_req.rd && i_req.addr[3:2] == 2'b01 |=> o_rd_data[6:4] == 3'h0; endproperty
  a_bw_pad: assert property (p_bw_pad) else $error("unused bandwidth bits set");
  property p_settle; quiet [*8] |=> $stable(o_active_bw_code) && $stable(o_active_sig_level_code); endproperty
  a_settle: assert property (p_settle) else $error("setting moved without cause");
  c_rd_bw: cover property (i_req.rd && i_req.addr == 4'hE);
  c_rd_lvl: cover property (i_req.rd && i_req.addr == 4'hF);
  c_wr: cover property (i_req.wr && i_req.wdata[7]);
endmodule
bind rss_top rss_asserts u_asserts (.i_clk, .i_rst_n, .i_req, .o_rd_data, .o_rd_valid, .i_speed_pin_low,
  .i_speed_pin_high, .o_active_bw_code, .o_active_sig_level_code);

// >>> sim/rss_host.sv
// host model issuing single byte register requests
`timescale 1ns/100ps
module rss_host (
  input  wire logic        i_clk,
  input  wire logic        i_rd_valid,
  input  wire logic [7:0]  i_rd_data,
  output rss_pkg::rss_req_t o_req
);
  initial o_req = '0;
  // idle fields show the inverse so a stale value is never mistaken for live data
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
    for (int n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        d = i_rd_data;
      end else @(posedge i_clk);
    end
  endtask
endmodule

// >>> sim/tb.sv
// self-checking bench for the rate setting selector
`timescale 1ns/100ps
module tb;
  localparam logic [3:0] BD [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
  localparam logic [6:0] LD [4] = '{7'h11, 7'h22, 7'h33, 7'h44};
  localparam logic [1:0] PINS [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic pin_low = 1'b0;
  logic pin_high = 1'b0;
  rss_pkg::rss_req_t req;
  logic [7:0] rd_data, m [16];
  logic rd_valid;
  logic [3:0] act_bw;
  logic [6:0] act_lvl;
  int errors = 0, check_count = 0, seed = 50;
  always #12.5 i_clk = ~i_clk;
  rss_host u_host (.i_clk(i_clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_req(req));
  rss_top #(.BW_DFLT_A(BD[0]), .BW_DFLT_B(BD[1]), .BW_DFLT_C(BD[2]), .BW_DFLT_D(BD[3]), .LVL_DFLT_A(LD[0]),
    .LVL_DFLT_B(LD[1]), .LVL_DFLT_C(LD[2]), .LVL_DFLT_D(LD[3])) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_req(req), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_speed_pin_low(pin_low),
    .i_speed_pin_high(pin_high), .o_active_bw_code(act_bw), .o_active_sig_level_code(act_lvl));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // model keeps only what the register file stores; status and holes stay zero
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    u_host.wr(a, d);
    if (a inside {[4:7]}) m[a] = d & 8'h8F;
    else if (a inside {[8:11]}) m[a] = d;
  endtask
  task automatic get(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    if (!ok) errors++;
    if (!ok) report_and_stop;
    chk(d, exp);
  endtask
  task automatic chk_act(input int s);
    logic [3:0] eb;
    logic [6:0] el;
    eb = m[4+s][7] ? m[4+s][3:0] : BD[s];
    el = m[8+s][7] ? m[8+s][6:0] : LD[s];
    chk({4'h0, act_bw}, {4'h0, eb});
    chk({1'b0, act_lvl}, {1'b0, el});
    get(4'hE, {4'h0, eb});
    get(4'hF, {1'b0, el});
  endtask
  initial begin
    foreach (m[i]) m[i] = 8'h00;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int a = 4; a < 12; a++) get(a[3:0], 8'h00);
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clk);
      {pin_high, pin_low} <= PINS[s];
      repeat (4) @(posedge i_clk);
      #1 chk_act(s);
      put(4'h4 + s[3:0], $random(seed) | 8'h80);
      put(4'h8 + s[3:0], (s == 0) ? 8'h80 : (s == 1) ? 8'hFF : $random(seed) | 8'h80);
      put(4'hE, $random(seed));
      put(4'hC, $random(seed));
      repeat (3) @(posedge i_clk);
      #1 chk_act(s);
      get(4'h4 + s[3:0], m[4+s]);
      get(4'h8 + s[3:0], m[8+s]);
      get(4'hC, 8'h00);
    end
    report_and_stop;
  end
endmodule
